// file: design/cache_bus_ctrl.sv
// Bus-side controller of a two-way write-through cache with snoop and backoff.
// Assumes bus inputs synchronous to clk_sys; strobes and the module select are active low.
// What this block does
// - A snoop strobe sampled while selected invalidates the address on the inputs, in any cycle.
// - Tag memory does one access per clock; competing accesses wait.
// - On collision: snoop lookup, then invalidation, then fill validation, then new lookup.
// - Snoop together with address strobe invalidates and starts memory like a read miss.
// - Sampled backoff releases the bus in the following clock.
// - Snoops keep being taken while backoff is active.
// - Backoff in a read hit invalidates that line; resumption misses.
// - Backoff in a fill aborts it; the restarted remainder is aborted too.
// - A fill ended by last-transfer before four transfers is never validated.
// - Address strobe in the clock backoff ends is ignored.
// - Small: set A4-A14; large: set A5-A15, sector A4; A2-A3 burst word.
// - Snoops act only while selected; the snoop address is latched internally.
// - Parity bits are stored and returned with each word like data bits.
// - Lookup starts on every memory-cycle address strobe taken while idle, whatever the module select.
// - I/O cycles are neither looked up nor started to memory.
// - Deselect disables outputs and snoops; internal lookups continue.
// - Write hits update only the enabled bytes; other partial transfers ignored.
// - Memory start for read misses and writes, normally first data phase, maybe later.
`timescale 1ns/10ps
module cache_bus_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic large_config,
  input wire logic [31:2] addr,
  input wire logic addr_strobe_n,
  input wire logic write_n,
  input wire logic mem_io_sel,
  input wire logic module_select_n,
  input wire logic ext_inval_strobe_n,
  input wire logic backoff_n,
  input wire logic burst_ready_n,
  input wire logic burst_last_n,
  input wire logic sys_cache_en_n,
  input wire logic [3:0] byte_enables_n,
  input wire logic [31:0] data_in,
  input wire logic [3:0] parity_bits_in,
  output logic mem_start_n,
  output logic bus_drive,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [31:0] rd_data,
  output logic [3:0] parity_bits_out
);
  logic [1:0] valid_mem [0:cache_pkg::WAYS-1][0:cache_pkg::SETS-1];
  logic [cache_pkg::TAG_W-1:0] tag_mem [0:cache_pkg::WAYS-1][0:cache_pkg::SETS-1];
  logic lru_mem [0:cache_pkg::SETS-1];
  logic [cache_pkg::ENTRY_W-1:0] data_mem [0:cache_pkg::WAYS-1][0:cache_pkg::DWORDS-1];

  cache_pkg::cyc_e cyc_reg;
  cache_pkg::tag_op_e op;
  logic [31:2] cyc_addr_reg;
  logic cyc_write_reg;
  logic cyc_sel_reg;
  logic force_miss_reg;
  logic lookup_pend_reg;
  logic [31:2] inv_addr_reg;
  logic inv_look_pend_reg;
  logic inv_do_pend_reg;
  logic inv_way_reg;
  logic [31:2] inv_do_addr_reg;
  logic val_pend_reg;
  logic [31:2] val_addr_reg;
  logic val_way_reg;
  logic hit_way_reg;
  logic write_hit_reg;
  logic [2:0] xfer_cnt_reg;
  logic cacheable_reg;
  logic fill_abort_reg;
  logic [31:2] abort_addr_reg;
  logic abort_line_reg;
  logic backoff_q_reg;
  logic mem_start_n_next;
  logic strobe_taken;
  logic inval_taken;
  logic backoff_act;
  logic [31:2] look_addr;
  logic [cache_pkg::SET_W-1:0] look_set;
  logic [cache_pkg::TAG_W-1:0] look_tag;
  logic look_sec;
  logic [1:0] way_hit;
  logic any_hit;
  logic hit_way;
  logic victim_way;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [cache_pkg::ENTRY_W-1:0] buf_in_data;
  logic [cache_pkg::ENTRY_W-1:0] buf_out_data;
  logic [cache_pkg::ENTRY_W-1:0] merged;
  logic [1:0] hit_word;
  logic [1:0] fill_word;

  function automatic logic [cache_pkg::SET_W-1:0] set_of(input logic [31:2] a,
                                                          input logic big);
    set_of = big ? a[cache_pkg::LARGE_SET_LSB +: cache_pkg::SET_W]
                 : a[cache_pkg::SMALL_SET_LSB +: cache_pkg::SET_W];
  endfunction : set_of

  function automatic logic [cache_pkg::TAG_W-1:0] tag_of(input logic [31:2] a,
                                                          input logic big);
    tag_of = big ? {1'b0, a[31:cache_pkg::LARGE_TAG_LSB]}
                 : a[31:cache_pkg::SMALL_TAG_LSB];
  endfunction : tag_of

  function automatic logic sec_of(input logic [31:2] a, input logic big);
    sec_of = big && a[cache_pkg::SECTOR_BIT];
  endfunction : sec_of

  function automatic logic [cache_pkg::DIDX_W-1:0] didx(input logic [31:2] a,
                                                         input logic big,
                                                         input logic [1:0] w);
    didx = {set_of(a, big), sec_of(a, big), w};
  endfunction : didx

  function automatic logic same_line(input logic [31:2] a, input logic [31:2] b);
    same_line = (a[31:4] == b[31:4]);
  endfunction : same_line

  // A strobe floating low as backoff ends is not a real cycle
  assign strobe_taken = !addr_strobe_n && mem_io_sel && !(backoff_q_reg && backoff_n);
  assign inval_taken = !ext_inval_strobe_n && !module_select_n;
  assign backoff_act = !backoff_n;

  // Single tag port: snoop work outranks validation, validation outranks new lookups
  always_comb begin
    if (inv_look_pend_reg) begin
      op = cache_pkg::OP_INV_LOOK;
    end else if (inv_do_pend_reg) begin
      op = cache_pkg::OP_INV_DO;
    end else if (val_pend_reg) begin
      op = cache_pkg::OP_VALIDATE;
    end else if (lookup_pend_reg) begin
      op = cache_pkg::OP_LOOKUP;
    end else begin
      op = cache_pkg::OP_NONE;
    end
  end

  assign look_addr = (op == cache_pkg::OP_INV_LOOK) ? inv_addr_reg : cyc_addr_reg;
  assign look_set = set_of(look_addr, large_config);
  assign look_tag = tag_of(look_addr, large_config);
  assign look_sec = sec_of(look_addr, large_config);

  genvar gw;
  generate
    for (gw = 0; gw < cache_pkg::WAYS; gw++) begin : g_way
      assign way_hit[gw] = valid_mem[gw][look_set][look_sec] &&
                           (tag_mem[gw][look_set] == look_tag);
    end
  endgenerate

  assign any_hit = |way_hit;
  assign hit_way = way_hit[1];
  // Prefer an empty way, else the least recently used one
  assign victim_way = (valid_mem[0][look_set] == cache_pkg::VALID_RST) ? 1'b0 :
                      (valid_mem[1][look_set] == cache_pkg::VALID_RST) ? 1'b1 :
                      lru_mem[look_set];

  // Snoop capture; the address is held here so address hold may drop it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inv_addr_reg <= '0;
      inv_look_pend_reg <= 1'b0;
    end else begin
      if (inval_taken) begin
        inv_addr_reg <= addr;
        inv_look_pend_reg <= 1'b1;
      end else if (op == cache_pkg::OP_INV_LOOK) begin
        inv_look_pend_reg <= 1'b0;
      end
    end
  end

  // Invalidation step, fed by a snoop hit or by backoff during a hit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inv_do_pend_reg <= 1'b0;
      inv_way_reg <= 1'b0;
      inv_do_addr_reg <= '0;
    end else begin
      if (op == cache_pkg::OP_INV_LOOK && any_hit) begin
        inv_do_pend_reg <= 1'b1;
        inv_way_reg <= hit_way;
        inv_do_addr_reg <= inv_addr_reg;
      end else if (cyc_reg == cache_pkg::CYC_HIT && backoff_act) begin
        inv_do_pend_reg <= 1'b1;
        inv_way_reg <= hit_way_reg;
        inv_do_addr_reg <= cyc_addr_reg;
      end else if (op == cache_pkg::OP_INV_DO) begin
        inv_do_pend_reg <= 1'b0;
      end
    end
  end

  // Tag, valid and replacement memory: one access per clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int s = 0; s < cache_pkg::SETS; s++) begin
        valid_mem[0][s] <= cache_pkg::VALID_RST;
        valid_mem[1][s] <= cache_pkg::VALID_RST;
        lru_mem[s] <= cache_pkg::LRU_RST;
      end
    end else begin
      case (op)
        cache_pkg::OP_INV_DO: begin
          valid_mem[inv_way_reg][set_of(inv_do_addr_reg, large_config)]
            [sec_of(inv_do_addr_reg, large_config)] <= 1'b0;
        end
        cache_pkg::OP_VALIDATE: begin
          tag_mem[val_way_reg][set_of(val_addr_reg, large_config)] <=
            tag_of(val_addr_reg, large_config);
          valid_mem[val_way_reg][set_of(val_addr_reg, large_config)]
            [sec_of(val_addr_reg, large_config)] <= 1'b1;
        end
        cache_pkg::OP_LOOKUP: begin
          if (any_hit && !force_miss_reg) begin
            lru_mem[look_set] <= !hit_way;
          end else if (!cyc_write_reg) begin
            // Tag is being replaced, so both sectors lose validity
            valid_mem[victim_way][look_set] <= cache_pkg::VALID_RST;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Cycle capture; lookup runs regardless of module select
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cyc_addr_reg <= '0;
      cyc_write_reg <= 1'b0;
      cyc_sel_reg <= 1'b0;
      force_miss_reg <= 1'b0;
      lookup_pend_reg <= 1'b0;
    end else begin
      if (strobe_taken && cyc_reg == cache_pkg::CYC_IDLE) begin
        cyc_addr_reg <= addr;
        cyc_write_reg <= !write_n;
        cyc_sel_reg <= !module_select_n;
        force_miss_reg <= inval_taken;
        lookup_pend_reg <= 1'b1;
      end else if (op == cache_pkg::OP_LOOKUP || backoff_act) begin
        lookup_pend_reg <= 1'b0;
      end
    end
  end

  // Cycle sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cyc_reg <= cache_pkg::CYC_IDLE;
      xfer_cnt_reg <= '0;
      hit_way_reg <= 1'b0;
      write_hit_reg <= 1'b0;
    end else if (backoff_act) begin
      cyc_reg <= cache_pkg::CYC_IDLE;
      xfer_cnt_reg <= '0;
    end else begin
      case (cyc_reg)
        cache_pkg::CYC_IDLE: begin
          if (strobe_taken) begin
            cyc_reg <= cache_pkg::CYC_LOOK;
          end
        end
        cache_pkg::CYC_LOOK: begin
          if (op == cache_pkg::OP_LOOKUP) begin
            xfer_cnt_reg <= '0;
            hit_way_reg <= any_hit ? hit_way : victim_way;
            write_hit_reg <= any_hit;
            // Deselected cycle is served elsewhere, so no burst ever ends it here
            if (!cyc_sel_reg) begin
              cyc_reg <= cache_pkg::CYC_IDLE;
            end else if (cyc_write_reg) begin
              cyc_reg <= cache_pkg::CYC_WRITE;
            end else if (any_hit && !force_miss_reg) begin
              cyc_reg <= cache_pkg::CYC_HIT;
            end else begin
              cyc_reg <= cache_pkg::CYC_FILL;
            end
          end
        end
        cache_pkg::CYC_HIT: begin
          if (buf_in_ready) begin
            xfer_cnt_reg <= xfer_cnt_reg + 3'h1;
            if (xfer_cnt_reg == cache_pkg::LAST_XFER) begin
              cyc_reg <= cache_pkg::CYC_IDLE;
            end
          end
        end
        cache_pkg::CYC_FILL: begin
          if (!burst_ready_n) begin
            xfer_cnt_reg <= xfer_cnt_reg + 3'h1;
            if (!burst_last_n) begin
              cyc_reg <= cache_pkg::CYC_IDLE;
            end
          end
        end
        cache_pkg::CYC_WRITE: begin
          if (!burst_ready_n && !burst_last_n) begin
            cyc_reg <= cache_pkg::CYC_IDLE;
          end
        end
        default: begin
          cyc_reg <= cache_pkg::CYC_IDLE;
        end
      endcase
    end
  end

  // Fill bookkeeping; an aborted line stays invalid across the restart
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cacheable_reg <= 1'b0;
      fill_abort_reg <= 1'b0;
      abort_addr_reg <= '0;
      abort_line_reg <= 1'b0;
      val_pend_reg <= 1'b0;
      val_addr_reg <= '0;
      val_way_reg <= 1'b0;
    end else begin
      if (op == cache_pkg::OP_VALIDATE) begin
        val_pend_reg <= 1'b0;
      end
      if (cyc_reg == cache_pkg::CYC_FILL && backoff_act) begin
        abort_addr_reg <= cyc_addr_reg;
        abort_line_reg <= 1'b1;
      end
      if (cyc_reg == cache_pkg::CYC_LOOK && op == cache_pkg::OP_LOOKUP) begin
        cacheable_reg <= 1'b0;
        fill_abort_reg <= abort_line_reg && same_line(abort_addr_reg, cyc_addr_reg);
        abort_line_reg <= 1'b0;
      end else if (cyc_reg == cache_pkg::CYC_FILL) begin
        if (op == cache_pkg::OP_INV_LOOK && same_line(inv_addr_reg, cyc_addr_reg)) begin
          fill_abort_reg <= 1'b1;
        end
        if (!burst_ready_n) begin
          if (!sys_cache_en_n) begin
            cacheable_reg <= 1'b1;
          end
          // Short burst never validates
          if (!burst_last_n && xfer_cnt_reg == cache_pkg::LAST_XFER &&
              (cacheable_reg || !sys_cache_en_n) && !fill_abort_reg && !backoff_act) begin
            val_pend_reg <= 1'b1;
            val_addr_reg <= cyc_addr_reg;
            val_way_reg <= hit_way_reg;
          end
        end
      end
    end
  end

  assign fill_word = cyc_addr_reg[3:2] ^ xfer_cnt_reg[1:0];
  assign hit_word = cyc_addr_reg[3:2] ^ xfer_cnt_reg[1:0];

  // Byte-lane merge keeps each parity bit with its byte
  generate
    for (gw = 0; gw < 4; gw++) begin : g_lane
      assign merged[gw*8 +: 8] = byte_enables_n[gw] ?
        data_mem[hit_way_reg][didx(cyc_addr_reg, large_config, cyc_addr_reg[3:2])][gw*8 +: 8] :
        data_in[gw*8 +: 8];
      assign merged[cache_pkg::DATA_W + gw] = byte_enables_n[gw] ?
        data_mem[hit_way_reg][didx(cyc_addr_reg, large_config, cyc_addr_reg[3:2])]
          [cache_pkg::DATA_W + gw] :
        parity_bits_in[gw];
    end
  endgenerate

  // Data array writes: fill words and write-hit merges
  always_ff @(posedge clk_sys) begin
    if (cyc_reg == cache_pkg::CYC_FILL && !burst_ready_n && !backoff_act) begin
      data_mem[hit_way_reg][didx(cyc_addr_reg, large_config, fill_word)] <=
        {parity_bits_in, data_in};
    end else if (cyc_reg == cache_pkg::CYC_WRITE && !burst_ready_n && write_hit_reg &&
                 !backoff_act) begin
      data_mem[hit_way_reg][didx(cyc_addr_reg, large_config, cyc_addr_reg[3:2])] <=
        merged;
    end
  end

  assign buf_in_valid = (cyc_reg == cache_pkg::CYC_HIT) && !backoff_act;
  assign buf_in_data = data_mem[hit_way_reg][didx(cyc_addr_reg, large_config, hit_word)];

  word_buffer u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(backoff_act),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(buf_out_data)
  );

  // Held words are returned with their parity, unchanged
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= '0;
      parity_bits_out <= '0;
    end else begin
      rd_data <= buf_out_data[cache_pkg::DATA_W-1:0];
      parity_bits_out <= buf_out_data[cache_pkg::ENTRY_W-1:cache_pkg::DATA_W];
    end
  end

  // Memory start: misses and writes of selected memory cycles only
  always_comb begin
    mem_start_n_next = 1'b1;
    if (cyc_reg == cache_pkg::CYC_LOOK && op == cache_pkg::OP_LOOKUP && cyc_sel_reg &&
        !backoff_act && (cyc_write_reg || !any_hit || force_miss_reg)) begin
      mem_start_n_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_start_n <= 1'b1;
      bus_drive <= 1'b0;
      backoff_q_reg <= 1'b0;
    end else begin
      mem_start_n <= mem_start_n_next;
      backoff_q_reg <= backoff_act;
      // Bus dropped the clock after backoff is seen
      bus_drive <= (cyc_reg == cache_pkg::CYC_HIT) && cyc_sel_reg && !backoff_act;
    end
  end
endmodule : cache_bus_ctrl

// file: design/cache_pkg.sv
// Shared constants for the bus-side cache controller.
// Assumes one system clock and a synchronous active-high reset.
package cache_pkg;
  localparam int WAYS = 2;
  localparam int SET_W = 11;
  localparam int SETS = 2048;
  localparam int TAG_W = 17;
  localparam int WORD_W = 2;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int ENTRY_W = 36;
  localparam int DIDX_W = 14;
  localparam int DWORDS = 16384;
  localparam int BUF_DEPTH = 2;
  // Set index position per configuration
  localparam int SMALL_SET_LSB = 4;
  localparam int LARGE_SET_LSB = 5;
  localparam int SECTOR_BIT = 4;
  localparam int SMALL_TAG_LSB = 15;
  localparam int LARGE_TAG_LSB = 16;
  // Transfers per line and last transfer count
  localparam logic [2:0] LINE_XFERS = 3'h4;
  localparam logic [2:0] LAST_XFER = 3'h3;
  localparam logic [1:0] VALID_RST = 2'h0;
  localparam logic LRU_RST = 1'b0;

  typedef enum logic [4:0] {
    CYC_IDLE = 5'b00001,
    CYC_LOOK = 5'b00010,
    CYC_HIT = 5'b00100,
    CYC_FILL = 5'b01000,
    CYC_WRITE = 5'b10000
  } cyc_e;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00001,
    OP_INV_LOOK = 5'b00010,
    OP_INV_DO = 5'b00100,
    OP_VALIDATE = 5'b01000,
    OP_LOOKUP = 5'b10000
  } tag_op_e;
endpackage : cache_pkg

// file: design/word_buffer.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock; flush drops all held words.
`timescale 1ns/10ps
module word_buffer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [cache_pkg::ENTRY_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [cache_pkg::ENTRY_W-1:0] out_data
);
  logic [cache_pkg::ENTRY_W-1:0] spare_reg;
  logic spare_valid_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Ready is the inverse of the second slot, so it comes from a flop
  assign in_ready = !spare_valid_reg;

  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      out_valid <= 1'b0;
      spare_valid_reg <= 1'b0;
    end else begin
      if (pop) begin
        out_valid <= spare_valid_reg || push;
        spare_valid_reg <= 1'b0;
      end else if (push && !out_valid) begin
        out_valid <= 1'b1;
      end else if (push) begin
        spare_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_data <= '0;
      spare_reg <= '0;
    end else begin
      if (pop) begin
        out_data <= spare_valid_reg ? spare_reg : in_data;
      end else if (push && !out_valid) begin
        out_data <= in_data;
      end
      if (push && out_valid && !pop) begin
        spare_reg <= in_data;
      end
    end
  end
endmodule : word_buffer

// file: tb/cache_bus_ctrl_properties.sv
// Port-level checker for the bus-side cache controller.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/10ps
module cache_bus_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic addr_strobe_n,
  input wire logic write_n,
  input wire logic mem_io_sel,
  input wire logic module_select_n,
  input wire logic backoff_n,
  input wire logic mem_start_n,
  input wire logic bus_drive,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [31:0] rd_data,
  input wire logic [3:0] parity_bits_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_io_ignored: assert property (
    !addr_strobe_n && !mem_io_sel |=> mem_start_n [*3]) else $error("start for io cycle");
  chk_deselect_quiet: assert property (
    !addr_strobe_n && module_select_n |=> mem_start_n [*3]) else $error("start while deselected");
  chk_backoff_release: assert property (
    !backoff_n |=> !bus_drive) else $error("bus kept after backoff");
  chk_release_strobe: assert property (
    $rose(backoff_n) && !addr_strobe_n |=> mem_start_n [*3]) else $error("release strobe taken");
  chk_start_pulse: assert property (
    $fell(mem_start_n) |=> mem_start_n) else $error("start pulse too long");
  chk_write_start: assert property (
    !addr_strobe_n && !write_n && mem_io_sel && !module_select_n && backoff_n
    && $past(backoff_n) |-> ##[2:5] !mem_start_n) else $error("no start for write");
  chk_valid_holds: assert property (
    rd_valid && !rd_ready && backoff_n |=> rd_valid) else $error("word dropped");
  chk_head_stable: assert property (
    (rd_valid && !rd_ready && backoff_n) [*3] |-> $stable(rd_data) && $stable(parity_bits_out))
    else $error("stalled word changed");
endmodule : cache_bus_ctrl_checker

bind cache_bus_ctrl cache_bus_ctrl_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .addr_strobe_n(addr_strobe_n), .write_n(write_n), .mem_io_sel(mem_io_sel),
  .module_select_n(module_select_n), .backoff_n(backoff_n), .mem_start_n(mem_start_n),
  .bus_drive(bus_drive), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .parity_bits_out(parity_bits_out));

// file: tb/memory_model.sv
// Memory-side model: answers each memory start with a burst or one write transfer.
// Assumes the bench holds addr and write_n steady through the cycle.
`timescale 1ns/10ps
module memory_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mem_start_n,
  input wire logic write_n,
  input wire logic backoff_n,
  input wire logic short_fill,
  input wire logic slow,
  input wire logic [31:2] addr,
  output logic burst_ready_n,
  output logic burst_last_n,
  output logic sys_cache_en_n,
  output logic [31:0] data_in,
  output logic [3:0] parity_bits_in
);
  logic active_reg;
  logic wr_reg;
  logic gap_reg;
  logic [31:4] line_reg;
  logic [1:0] w_reg;
  logic [2:0] k_reg;
  logic [35:0] last_reg;
  logic [1:0] w;
  logic [2:0] end_k;
  assign w = w_reg ^ k_reg[1:0];
  assign end_k = wr_reg ? 3'h0 : (short_fill ? 3'h2 : 3'h3);
  assign burst_ready_n = !(active_reg && !gap_reg);
  assign burst_last_n = !(active_reg && k_reg == end_k);
  assign sys_cache_en_n = !active_reg;
  // Idle bus shows a changing pattern so a stale word never looks valid
  assign {parity_bits_in, data_in} = burst_ready_n ? ~last_reg
    : {2'h2, w, line_reg, 2'h0, w} ^ {36{wr_reg}};
  always_ff @(posedge clk_sys) begin
    last_reg <= {parity_bits_in, data_in};
    gap_reg <= slow && !gap_reg;
    if (rst || !backoff_n) begin
      active_reg <= 1'b0;
    end else if (!mem_start_n) begin
      active_reg <= 1'b1;
      wr_reg <= !write_n;
      line_reg <= addr[31:4];
      w_reg <= addr[3:2];
      k_reg <= 3'h0;
    end else if (active_reg && !burst_ready_n) begin
      k_reg <= k_reg + 3'h1;
      active_reg <= burst_last_n;
    end
  end
endmodule : memory_model

// file: tb/test_cache_bus_ctrl.sv
// Self-checking bench for the bus-side cache controller.
// Assumes memory_model on the memory side and the bound port checker.
`timescale 1ns/10ps
module test_cache_bus_ctrl;
  typedef struct {
    logic [31:0] a; logic wr_n; logic mio; logic sel_n; logic [3:0] be_n; logic snp;
    int st; int nw; logic [31:0] xm;
  } row_s;
  localparam logic [31:0] A = 32'h0001_2348;
  localparam logic [31:0] B = 32'h0001_A348;
  localparam logic [31:0] C = 32'h0000_5550;
  localparam logic [31:0] D = 32'h0008_7770;
  logic clk_sys, rst, addr_strobe_n, write_n, mem_io_sel, module_select_n, ext_inval_strobe_n;
  logic backoff_n, rd_ready, short_fill, slow, burst_ready_n, burst_last_n, sys_cache_en_n;
  logic mem_start_n, bus_drive, rd_valid;
  logic [31:2] addr;
  logic [3:0] byte_enables_n, parity_bits_in, parity_bits_out;
  logic [31:0] data_in, rd_data;
  int fails, check_count, st, nw, k;
  row_s rows [12];

  cache_bus_ctrl uut (.clk_sys(clk_sys), .rst(rst), .large_config(1'b0), .addr(addr),
    .addr_strobe_n(addr_strobe_n), .write_n(write_n), .mem_io_sel(mem_io_sel),
    .module_select_n(module_select_n), .ext_inval_strobe_n(ext_inval_strobe_n),
    .backoff_n(backoff_n), .burst_ready_n(burst_ready_n), .burst_last_n(burst_last_n),
    .sys_cache_en_n(sys_cache_en_n), .byte_enables_n(byte_enables_n), .data_in(data_in),
    .parity_bits_in(parity_bits_in), .mem_start_n(mem_start_n), .bus_drive(bus_drive),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .parity_bits_out(parity_bits_out));
  memory_model u_mem (.clk_sys(clk_sys), .rst(rst), .mem_start_n(mem_start_n),
    .write_n(write_n), .backoff_n(backoff_n), .short_fill(short_fill), .slow(slow),
    .addr(addr), .burst_ready_n(burst_ready_n), .burst_last_n(burst_last_n),
    .sys_cache_en_n(sys_cache_en_n), .data_in(data_in), .parity_bits_in(parity_bits_in));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Line word n in burst order; xm marks bytes rewritten by a write
  function automatic logic [35:0] word(input logic [31:0] a, input int n, input logic [31:0] xm);
    logic [1:0] w;
    w = a[3:2] ^ n[1:0];
    return {{2'h2, w} ^ {|xm[31:24], |xm[23:16], |xm[15:8], |xm[7:0]},
      {a[31:4], 2'h0, w} ^ xm};
  endfunction : word

  task automatic strobe(input logic [31:0] a, input logic snp);
    @(posedge clk_sys);
    addr <= a[31:2];
    addr_strobe_n <= 1'b0;
    ext_inval_strobe_n <= !snp;
    @(posedge clk_sys);
    addr_strobe_n <= 1'b1;
    ext_inval_strobe_n <= 1'b1;
  endtask : strobe

  // Consumer stalls each word three cycles so the buffer fills and refuses
  task automatic run(input row_s r);
    st = 0;
    nw = 0;
    @(posedge clk_sys);
    write_n <= r.wr_n;
    mem_io_sel <= r.mio;
    module_select_n <= r.sel_n;
    byte_enables_n <= r.be_n;
    strobe(r.a, r.snp);
    for (k = 0; k < 24; k++) begin
      @(negedge clk_sys);
      if (mem_start_n === 1'b0) st++;
      if (rd_valid === 1'b1) begin
        repeat (2) @(negedge clk_sys);
        check({parity_bits_out, rd_data}, word(r.a, nw, nw == 0 ? r.xm : 32'h0));
        @(posedge clk_sys);
        rd_ready <= 1'b1;
        @(posedge clk_sys);
        rd_ready <= 1'b0;
        nw++;
      end
    end
  endtask : run

  task automatic run_rd(input logic [31:0] a, input int exp_st, input int exp_nw);
    run('{a, 1, 1, 0, 4'hf, 0, 0, 0, 32'h0});
    check(36'(st), 36'(exp_st));
    check(36'(nw), 36'(exp_nw));
  endtask : run_rd

  initial begin
    #150000;
    fails++;
    summarize();
  end

  initial begin
    rows = '{'{A, 1, 1, 0, 4'hf, 0, 1, 0, 32'h0}, '{A, 1, 1, 0, 4'hf, 0, 0, 4, 32'h0},
      '{A, 0, 1, 0, 4'he, 0, 1, 0, 32'h0}, '{A, 1, 1, 0, 4'hf, 0, 0, 4, 32'h0000_00ff},
      '{A, 1, 0, 0, 4'hf, 0, 0, 0, 32'h0}, '{B, 1, 1, 1, 4'hf, 0, 0, 0, 32'h0},
      '{B, 1, 1, 0, 4'hf, 0, 1, 0, 32'h0}, '{A, 1, 1, 0, 4'hf, 0, 0, 4, 32'h0000_00ff},
      '{C, 0, 1, 0, 4'h0, 0, 1, 0, 32'h0}, '{C, 1, 1, 0, 4'hf, 0, 1, 0, 32'h0},
      '{A, 1, 1, 0, 4'hf, 1, 1, 0, 32'h0}, '{A, 1, 1, 0, 4'hf, 0, 0, 4, 32'h0}};
    {rst, addr_strobe_n, write_n, mem_io_sel, ext_inval_strobe_n, backoff_n} = 6'h3f;
    {module_select_n, rd_ready, short_fill, slow} = 4'h0;
    addr = 30'h0;
    byte_enables_n = 4'hf;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check({mem_start_n, bus_drive, rd_valid}, 3'h4);
    foreach (rows[i]) begin
      run(rows[i]);
      check(36'(st), 36'(rows[i].st));
      check(36'(nw), 36'(rows[i].nw));
    end
    // Backoff in a hit, strobe left low on the release edge
    strobe(A, 1'b0);
    for (k = 0; k < 10 && bus_drive !== 1'b1; k++) @(negedge clk_sys);
    check(36'(bus_drive), 36'h1);
    @(posedge clk_sys);
    backoff_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    backoff_n <= 1'b1;
    addr_strobe_n <= 1'b0;
    @(posedge clk_sys);
    addr_strobe_n <= 1'b1;
    st = 0;
    repeat (6) @(negedge clk_sys) st += int'(mem_start_n === 1'b0);
    check(36'(st), 36'h0);
    run_rd(A, 1, 0);
    run_rd(A, 0, 4);
    // Backoff in a fill with a snoop meanwhile, then a slow restart and two slow short refills
    strobe(D, 1'b0);
    for (k = 0; k < 10 && burst_ready_n !== 1'b0; k++) @(negedge clk_sys);
    @(posedge clk_sys);
    backoff_n <= 1'b0;
    addr <= A[31:2];
    ext_inval_strobe_n <= 1'b0;
    @(posedge clk_sys);
    ext_inval_strobe_n <= 1'b1;
    @(posedge clk_sys);
    backoff_n <= 1'b1;
    slow <= 1'b1;
    run_rd(D, 1, 0);
    short_fill <= 1'b1;
    run_rd(D, 1, 0);
    run_rd(D, 1, 0);
    short_fill <= 1'b0;
    slow <= 1'b0;
    run_rd(A, 1, 0);
    summarize();
  end
endmodule : test_cache_bus_ctrl
